/* hw/mrr_pkg.sv */
// Purpose: shared constants and types for the mode register read path
// Assumes: one 50 MHz clock shared by controller and device
// Notes:   one data beat per clock cycle in this model
package mrr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and widths
  localparam int unsigned CLK_PS  = 20000;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned DQ_W    = 32;
  localparam int unsigned CA_W    = 10;
  localparam int unsigned TMR_W   = 5;
  localparam int unsigned LAT_W   = 4;
  localparam int unsigned TSI_W   = 21;

  // least time in ps to whole cycles, rounded up, never below one
  function automatic int unsigned ps_to_cyc_up(input int unsigned ps);
    int unsigned c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c == 0) ? 1 : c;
  endfunction : ps_to_cyc_up

  ////////////////////////////////////////////////////////////////////////////
  // latencies and burst
  localparam int unsigned RL             = 8;
  localparam int unsigned WL             = 4;
  localparam int unsigned BL             = 8;
  localparam int unsigned MRR_BL         = 8;
  localparam int unsigned MRR_PERIOD_CYC = 4;

  localparam int unsigned DQSCK_MAX_PS   = 5500;
  localparam int unsigned WTR_PS         = 7500;
  localparam int unsigned RCD_PS         = 18000;
  localparam int unsigned DQSCK_MAX_CYC  = ps_to_cyc_up(DQSCK_MAX_PS);
  localparam int unsigned WTR_CYC        = ps_to_cyc_up(WTR_PS);
  localparam int unsigned POWERDOWN_TO_REGREAD_DELAY = ps_to_cyc_up(RCD_PS);

  localparam int unsigned MRR_TO_MRW_CYC = RL + DQSCK_MAX_CYC + MRR_BL / 2 + 1;
  localparam int unsigned RD_TO_MRR_CYC  = BL / 2;
  localparam int unsigned WR_TO_MRR_CYC  = WL + 1 + BL / 2 + WTR_CYC;
  localparam int unsigned CAP_DLY        = RL + 1;

  // sensor update interval, ms and cycles
  localparam int unsigned SENSOR_UPDATE_INTERVAL_MS = 32;
  localparam int unsigned SENSOR_INTERVAL_CYC = SENSOR_UPDATE_INTERVAL_MS * CLK_MHZ * 1000;

  ////////////////////////////////////////////////////////////////////////////
  // command encodings on the rising-edge CA bits
  localparam logic [3:0] ENC_MRR = 4'h8;
  localparam logic [3:0] ENC_MRW = 4'h0;
  localparam logic [2:0] ENC_RD  = 3'h5;
  localparam logic [2:0] ENC_WR  = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses and fixed contents
  localparam logic [7:0] MA_TEMP      = 8'h04;
  localparam logic [7:0] MA_CAL_A     = 8'h20;
  localparam logic [7:0] MA_CAL_B     = 8'h28;
  localparam logic [7:0] MA_RSVD_MIN  = 8'h40;
  localparam logic [7:0] RSVD_DATA    = 8'h00;
  localparam logic [7:0] CAL_A_PAT    = 8'h55;
  localparam logic [7:0] CAL_B_PAT    = 8'hcc;
  localparam logic [2:0] TEMP_RST     = 3'h3;

  typedef enum logic [2:0] {
    MRR_CMD_MRR,
    MRR_CMD_MRW,
    MRR_CMD_RD,
    MRR_CMD_WR,
    MRR_CMD_PDE,
    MRR_CMD_PDX
  } mrr_cmd_t;

endpackage : mrr_pkg

/* hw/mrr_if.sv */
// Purpose: command/address and data strobe wires between controller and device
// Assumes: both ends on the same clock
// Notes:   data lanes carry device data only while dq_oe is high and read zero otherwise
`timescale 1ns/1ns
interface mrr_if;
  logic        cke;
  logic        cs_n;
  logic [9:0]  ca_r;
  logic [9:0]  ca_f;
  logic [31:0] dq_o;
  logic        dq_oe;
  logic        dqs_o;
  logic        dqs_oe;

  modport dev
  (
    input  cke,
    input  cs_n,
    input  ca_r,
    input  ca_f,
    output dq_o,
    output dq_oe,
    output dqs_o,
    output dqs_oe
  );

  modport ctrl
  (
    output cke,
    output cs_n,
    output ca_r,
    output ca_f,
    input  dq_o,
    input  dq_oe,
    input  dqs_o,
    input  dqs_oe
  );
endinterface : mrr_if

/* hw/mrr_device.sv */
// Purpose: device end of the mode register read path
// Assumes: controller keeps command spacing; one beat per clock
// Notes:   strobe output delay taken as zero cycles
`timescale 1ns/1ns
module mrr_device
#(
  parameter int unsigned SENSOR_INTERVAL_CYC = mrr_pkg::SENSOR_INTERVAL_CYC
)
(
  input  wire logic       clock,
  input  wire logic       reset,
  mrr_if.dev              link,
  input  wire logic [2:0] temp_sensor,
  output logic      [7:0] mr_addr,
  input  wire logic [7:0] mr_data,
  output logic            busy
);

  typedef enum logic [1:0] {
    MRR_DS_IDLE,
    MRR_DS_WAIT,
    MRR_DS_BURST
  } mrr_dev_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_cal(input logic [7:0] a);
    return (a == mrr_pkg::MA_CAL_A) || (a == mrr_pkg::MA_CAL_B);
  endfunction : is_cal

  // one beat of the burst, all 32 lanes
  function automatic logic [31:0] beat_word(input logic [7:0] a,
                                            input logic [2:0] beat,
                                            input logic [7:0] byte0);
    logic b;
    b = 1'b0;
    if (a == mrr_pkg::MA_CAL_A)
    begin
      b = mrr_pkg::CAL_A_PAT[beat];
    end
    else if (a == mrr_pkg::MA_CAL_B)
    begin
      b = mrr_pkg::CAL_B_PAT[beat];
    end
    if (is_cal(a))
    begin
      return {32{b}};
    end
    else if (beat == 3'h0)
    begin
      return {24'h000000, byte0};
    end
    else
    begin
      return 32'h00000000;
    end
  endfunction : beat_word

  ////////////////////////////////////////////////////////////////////////////
  // temperature status

  localparam int unsigned TSI_W_L = mrr_pkg::TSI_W - 1;

  logic [2:0]       ts_s1_reg;
  logic [2:0]       ts_s2_reg;
  logic [2:0]       temp_reg;
  logic [2:0]       temp_next;
  logic [TSI_W_L:0] tsi_reg;
  logic [TSI_W_L:0] tsi_next;
  logic             cke_d_reg;
  logic             wake;

  // exit from power-down or self-refresh shows as cke rising
  assign wake = link.cke && !cke_d_reg;

  always_comb
  begin
    temp_next = temp_reg;
    tsi_next  = tsi_reg + 1'b1;
    // margin for a 2 degree rise lives in the update period, not in logic
    if ((tsi_reg == mrr_pkg::TSI_W'(SENSOR_INTERVAL_CYC - 1)) || wake)
    begin
      temp_next = ts_s2_reg;
      tsi_next  = '0;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ts_s1_reg <= 3'h0;
      ts_s2_reg <= 3'h0;
      temp_reg  <= mrr_pkg::TEMP_RST;
      tsi_reg   <= '0;
      // cke idles high; a low value here would fake a wake edge
      cke_d_reg <= 1'b1;
    end
    else
    begin
      ts_s1_reg <= temp_sensor;
      ts_s2_reg <= ts_s1_reg;
      temp_reg  <= temp_next;
      tsi_reg   <= tsi_next;
      cke_d_reg <= link.cke;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode and burst

  mrr_dev_state_t           state_reg;
  mrr_dev_state_t           state_next;
  logic [7:0]               addr_reg;
  logic [7:0]               addr_next;
  logic [mrr_pkg::LAT_W-1:0] lat_reg;
  logic [mrr_pkg::LAT_W-1:0] lat_next;
  logic [2:0]               beat_reg;
  logic [2:0]               beat_next;
  logic [31:0]              dq_reg;
  logic [31:0]              dq_next;
  logic                     oe_reg;
  logic                     oe_next;
  logic                     dqs_reg;
  logic                     dqs_next;
  logic                     mrr_hit;
  logic [7:0]               byte0;

  assign mrr_hit = link.cke && !link.cs_n && (link.ca_r[3:0] == mrr_pkg::ENC_MRR);

  // low byte of beat zero; reserved space answers a fixed value
  always_comb
  begin
    if (addr_reg == mrr_pkg::MA_TEMP)
    begin
      byte0 = {5'h00, temp_reg};
    end
    else if (addr_reg >= mrr_pkg::MA_RSVD_MIN)
    begin
      byte0 = mrr_pkg::RSVD_DATA;
    end
    else
    begin
      byte0 = mr_data;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    addr_next  = addr_reg;
    lat_next   = lat_reg;
    beat_next  = beat_reg;
    dq_next    = 32'h00000000;
    oe_next    = 1'b0;
    dqs_next   = 1'b0;
    case (state_reg)
      MRR_DS_IDLE:
      begin
        // no bank state is touched on the way through
        if (mrr_hit)
        begin
          addr_next  = {link.ca_r[9:4], link.ca_f[1:0]};
          lat_next   = mrr_pkg::LAT_W'(mrr_pkg::RL - 1);
          state_next = MRR_DS_WAIT;
        end
      end
      MRR_DS_WAIT:
      begin
        // commands here are taken as NOPs and ignored
        if (lat_reg == '0)
        begin
          dq_next    = beat_word(addr_reg, 3'h0, byte0);
          oe_next    = 1'b1;
          dqs_next   = 1'b1;
          beat_next  = 3'h1;
          state_next = MRR_DS_BURST;
        end
        else
        begin
          lat_next = lat_reg - 1'b1;
        end
      end
      MRR_DS_BURST:
      begin
        dq_next   = beat_word(addr_reg, beat_reg, byte0);
        oe_next   = 1'b1;
        dqs_next  = ~dqs_reg;
        beat_next = beat_reg + 1'b1;
        // fixed eight beats whatever burst length is programmed
        if (beat_reg == 3'(mrr_pkg::MRR_BL - 1))
        begin
          state_next = MRR_DS_IDLE;
        end
      end
      default:
      begin
        state_next = MRR_DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= MRR_DS_IDLE;
      addr_reg  <= 8'h00;
      lat_reg   <= '0;
      beat_reg  <= 3'h0;
      dq_reg    <= 32'h00000000;
      oe_reg    <= 1'b0;
      dqs_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      lat_reg   <= lat_next;
      beat_reg  <= beat_next;
      dq_reg    <= dq_next;
      oe_reg    <= oe_next;
      dqs_reg   <= dqs_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.dq_o   = dq_reg;
  assign link.dq_oe  = oe_reg;
  assign link.dqs_o  = dqs_reg;
  assign link.dqs_oe = oe_reg;
  assign mr_addr     = addr_reg;
  assign busy        = (state_reg != MRR_DS_IDLE);

endmodule : mrr_device

/* hw/mrr_ctrl.sv */
// Purpose: controller end issuing register reads and spacing commands
// Assumes: device answers on the same clock; one beat per clock
// Notes:   read and write data transfers themselves are not carried
`timescale 1ns/1ns
module mrr_ctrl
(
  input  wire logic              clock,
  input  wire logic              reset,
  mrr_if.ctrl                    link,
  input  wire logic              cmd_valid,
  input  wire mrr_pkg::mrr_cmd_t cmd_kind,
  input  wire logic [7:0]        cmd_addr,
  input  wire logic [7:0]        cmd_op,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data,
  output logic                   powered_down
);

  typedef enum logic [1:0] {
    MRR_CS_IDLE,
    MRR_CS_WAIT,
    MRR_CS_BEAT
  } mrr_cap_state_t;

  localparam int unsigned TW = mrr_pkg::TMR_W;

  // count down, but never below a newly requested spacing
  function automatic logic [TW-1:0] dec_max(input logic [TW-1:0] cur,
                                            input logic          ld,
                                            input int unsigned   gap);
    logic [TW-1:0] d;
    d = (cur == '0) ? '0 : cur - 1'b1;
    if (ld && (TW'(gap - 1) > d))
    begin
      d = TW'(gap - 1);
    end
    return d;
  endfunction : dec_max

  ////////////////////////////////////////////////////////////////////////////
  // spacing and command drive

  logic [TW-1:0]  any_reg;
  logic [TW-1:0]  any_next;
  logic [TW-1:0]  mrr_blk_reg;
  logic [TW-1:0]  mrr_blk_next;
  logic [TW-1:0]  mrw_blk_reg;
  logic [TW-1:0]  mrw_blk_next;
  logic [TW-1:0]  blk_rd;
  logic [TW-1:0]  blk_wr;
  logic           pd_reg;
  logic           pd_next;
  logic           cs_n_reg;
  logic           cs_n_next;
  logic [9:0]     ca_r_reg;
  logic [9:0]     ca_r_next;
  logic [9:0]     ca_f_reg;
  logic [9:0]     ca_f_next;
  logic           acc;
  mrr_cap_state_t cap_reg;
  mrr_cap_state_t cap_next;

  always_comb
  begin
    cmd_ready = 1'b0;
    if (pd_reg)
    begin
      cmd_ready = (cmd_kind == mrr_pkg::MRR_CMD_PDX);
    end
    else if (any_reg == '0)
    begin
      case (cmd_kind)
        mrr_pkg::MRR_CMD_MRR: cmd_ready = (mrr_blk_reg == '0) && (cap_reg == MRR_CS_IDLE);
        mrr_pkg::MRR_CMD_MRW: cmd_ready = (mrw_blk_reg == '0);
        mrr_pkg::MRR_CMD_PDE: cmd_ready = (cap_reg == MRR_CS_IDLE);
        mrr_pkg::MRR_CMD_PDX: cmd_ready = 1'b0;
        default:              cmd_ready = 1'b1;
      endcase
    end
  end

  assign acc = cmd_valid && cmd_ready;

  always_comb
  begin
    any_next     = dec_max(any_reg, acc && (cmd_kind == mrr_pkg::MRR_CMD_MRR),
                           mrr_pkg::MRR_PERIOD_CYC);
    mrw_blk_next = dec_max(mrw_blk_reg, acc && (cmd_kind == mrr_pkg::MRR_CMD_MRR),
                           mrr_pkg::MRR_TO_MRW_CYC);
    // chained loads; each stage re-adds the step the next one takes off
    blk_rd       = dec_max(mrr_blk_reg, acc && (cmd_kind == mrr_pkg::MRR_CMD_RD),
                           mrr_pkg::RD_TO_MRR_CYC) + 1'b1;
    blk_wr       = dec_max(blk_rd, acc && (cmd_kind == mrr_pkg::MRR_CMD_WR),
                           mrr_pkg::WR_TO_MRR_CYC) + 1'b1;
    mrr_blk_next = dec_max(blk_wr, acc && (cmd_kind == mrr_pkg::MRR_CMD_PDX),
                           mrr_pkg::POWERDOWN_TO_REGREAD_DELAY);
    pd_next      = pd_reg;
    if (acc && (cmd_kind == mrr_pkg::MRR_CMD_PDE))
    begin
      pd_next = 1'b1;
    end
    else if (acc && (cmd_kind == mrr_pkg::MRR_CMD_PDX))
    begin
      pd_next = 1'b0;
    end
    cs_n_next = 1'b1;
    ca_r_next = 10'h000;
    ca_f_next = 10'h000;
    if (acc)
    begin
      case (cmd_kind)
        mrr_pkg::MRR_CMD_MRR:
        begin
          cs_n_next = 1'b0;
          ca_r_next = {cmd_addr[7:2], mrr_pkg::ENC_MRR};
          ca_f_next = {8'h00, cmd_addr[1:0]};
        end
        mrr_pkg::MRR_CMD_MRW:
        begin
          cs_n_next = 1'b0;
          ca_r_next = {cmd_addr[7:2], mrr_pkg::ENC_MRW};
          ca_f_next = {cmd_op, cmd_addr[1:0]};
        end
        mrr_pkg::MRR_CMD_RD:
        begin
          cs_n_next = 1'b0;
          ca_r_next = {7'h00, mrr_pkg::ENC_RD};
        end
        mrr_pkg::MRR_CMD_WR:
        begin
          cs_n_next = 1'b0;
          ca_r_next = {7'h00, mrr_pkg::ENC_WR};
        end
        default:
        begin
          cs_n_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      any_reg     <= '0;
      mrr_blk_reg <= '0;
      mrw_blk_reg <= '0;
      pd_reg      <= 1'b0;
      cs_n_reg    <= 1'b1;
      ca_r_reg    <= 10'h000;
      ca_f_reg    <= 10'h000;
    end
    else
    begin
      any_reg     <= any_next;
      mrr_blk_reg <= mrr_blk_next;
      mrw_blk_reg <= mrw_blk_next;
      pd_reg      <= pd_next;
      cs_n_reg    <= cs_n_next;
      ca_r_reg    <= ca_r_next;
      ca_f_reg    <= ca_f_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer capture

  logic [mrr_pkg::LAT_W-1:0] wait_reg;
  logic [mrr_pkg::LAT_W-1:0] wait_next;
  logic [2:0]                beat_reg;
  logic [2:0]                beat_next;
  logic [7:0]                addr_reg;
  logic [7:0]                addr_next;
  logic [7:0]                byte_reg;
  logic [7:0]                byte_next;
  logic [7:0]                pat_reg;
  logic [7:0]                pat_next;
  logic                      rv_next;
  logic                      rv_reg;
  logic [7:0]                rd_next;
  logic [7:0]                rd_reg;

  always_comb
  begin
    cap_next  = cap_reg;
    wait_next = wait_reg;
    beat_next = beat_reg;
    addr_next = addr_reg;
    byte_next = byte_reg;
    pat_next  = pat_reg;
    rv_next   = 1'b0;
    rd_next   = rd_reg;
    case (cap_reg)
      MRR_CS_IDLE:
      begin
        if (acc && (cmd_kind == mrr_pkg::MRR_CMD_MRR))
        begin
          wait_next = mrr_pkg::LAT_W'(mrr_pkg::CAP_DLY);
          addr_next = cmd_addr;
          cap_next  = MRR_CS_WAIT;
        end
      end
      MRR_CS_WAIT:
      begin
        if (wait_reg == '0)
        begin
          byte_next   = link.dq_o[7:0];
          pat_next[0] = link.dq_o[0];
          beat_next   = 3'h1;
          cap_next    = MRR_CS_BEAT;
        end
        else
        begin
          wait_next = wait_reg - 1'b1;
        end
      end
      default:
      begin
        pat_next[beat_reg] = link.dq_o[0];
        beat_next          = beat_reg + 1'b1;
        if (beat_reg == 3'h7)
        begin
          rv_next  = 1'b1;
          rd_next  = ((addr_reg == mrr_pkg::MA_CAL_A) || (addr_reg == mrr_pkg::MA_CAL_B)) ? pat_next : byte_reg;
          cap_next = MRR_CS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      cap_reg  <= MRR_CS_IDLE;
      wait_reg <= '0;
      beat_reg <= 3'h0;
      addr_reg <= 8'h00;
      byte_reg <= 8'h00;
      pat_reg  <= 8'h00;
      rv_reg   <= 1'b0;
      rd_reg   <= 8'h00;
    end
    else
    begin
      cap_reg  <= cap_next;
      wait_reg <= wait_next;
      beat_reg <= beat_next;
      addr_reg <= addr_next;
      byte_reg <= byte_next;
      pat_reg  <= pat_next;
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
    end
  end

  assign link.cke     = ~pd_reg;
  assign link.cs_n    = cs_n_reg;
  assign link.ca_r    = ca_r_reg;
  assign link.ca_f    = ca_f_reg;
  assign rsp_valid    = rv_reg;
  assign rsp_data     = rd_reg;
  assign powered_down = pd_reg;

endmodule : mrr_ctrl

/* dv/mrr_monitor.sv */
// Purpose: wire checks between controller and device ends
// Assumes: one clock, reset asynchronous active high
// Notes:   ca_r reads zero between commands
`timescale 1ns/1ns
module mrr_monitor
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic [9:0]  ca_r,
  input wire logic [9:0]  ca_f,
  input wire logic [31:0] dq_o,
  input wire logic        dq_oe,
  input wire logic        dqs_o,
  input wire logic        dqs_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  logic       mrr_seen;
  logic [4:0] mrr_gap_reg;
  logic [4:0] mrr_gap_next;
  logic [4:0] rd_gap_reg;
  logic [4:0] rd_gap_next;
  logic [4:0] wr_gap_reg;
  logic [4:0] wr_gap_next;

  assign mrr_seen = cke && !cs_n && ca_r[3:0] == 4'h8;

  //////////////////////////////////////////////////////////////////////////////
  // saturating counts since the last MRR, read and write commands; start saturated so reset is no command
  always_comb
  begin
    mrr_gap_next = (mrr_gap_reg == 5'h1f) ? mrr_gap_reg : mrr_gap_reg + 5'h01;
    rd_gap_next  = (rd_gap_reg == 5'h1f) ? rd_gap_reg : rd_gap_reg + 5'h01;
    wr_gap_next  = (wr_gap_reg == 5'h1f) ? wr_gap_reg : wr_gap_reg + 5'h01;
    if (mrr_seen)
      mrr_gap_next = 5'h01;
    if (!cs_n && ca_r[2:0] == 3'h5)
      rd_gap_next = 5'h01;
    if (!cs_n && ca_r[2:0] == 3'h1)
      wr_gap_next = 5'h01;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mrr_gap_reg <= 5'h1f;
      rd_gap_reg  <= 5'h1f;
      wr_gap_reg  <= 5'h1f;
    end
    else
    begin
      mrr_gap_reg <= mrr_gap_next;
      rd_gap_reg  <= rd_gap_next;
      wr_gap_reg  <= wr_gap_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  burst_start_a: assert property (mrr_seen |-> ##9 $rose(dq_oe))
    else $error("burst not started at read latency");
  burst_len_a: assert property ($rose(dq_oe) |-> dq_oe [*8] ##1 !dq_oe)
    else $error("burst not eight beats");
  strobe_en_a: assert property (dqs_oe == dq_oe)
    else $error("strobe enable differs from data enable");
  strobe_toggle_a: assert property (dq_oe |-> ($rose(dq_oe) ? dqs_o : dqs_o != $past(dqs_o)))
    else $error("strobe not toggling in burst");
  calib_a_a: assert property (mrr_seen && ca_r[9:4] == 6'h08 && ca_f[1:0] == 2'h0 |-> ##9
    &dq_o ##1 ~|dq_o ##1 &dq_o ##1 ~|dq_o ##1 &dq_o ##1 ~|dq_o ##1 &dq_o ##1 ~|dq_o)
    else $error("pattern a wrong");
  calib_b_a: assert property (mrr_seen && ca_r[9:4] == 6'h0a && ca_f[1:0] == 2'h0 |-> ##9
    ~|dq_o ##1 ~|dq_o ##1 &dq_o ##1 &dq_o ##1 ~|dq_o ##1 ~|dq_o ##1 &dq_o ##1 &dq_o)
    else $error("pattern b wrong");
  reserved_zero_a: assert property (mrr_seen && ca_r[9:8] != 2'h0 |-> ##9 (dq_o == 32'h0) [*8])
    else $error("reserved read not zero");
  nop_after_a: assert property (mrr_seen |=> cs_n [*3])
    else $error("command inside read command period");
  mrw_gap_a: assert property (!cs_n && ca_r[3:0] == 4'h0 |-> mrw_gap_ok())
    else $error("write too soon after read");
  rd_gap_a: assert property (mrr_seen |-> rd_gap_reg >= 5'h04)
    else $error("register read too soon after read");
  wr_gap_a: assert property (mrr_seen |-> wr_gap_reg >= 5'h0a)
    else $error("register read too soon after write");

  function automatic logic mrw_gap_ok();
    return mrr_gap_reg >= 5'h0e;
  endfunction : mrw_gap_ok

  cover property (mrr_seen && ca_r[9:4] == 6'h0a);
  cover property (!cs_n && ca_r[3:0] == 4'h0);
  cover property ($rose(cke));
endmodule : mrr_monitor

/* dv/tb_mode_register_read_path.sv */
// Purpose: both ends joined, user sides driven and checked
// Assumes: sensor interval shortened to 64 cycles
// Notes:   responses checked in order against a queue
`timescale 1ns/1ns
module tb_mode_register_read_path;
  logic              clock;
  logic              reset;
  logic              cmd_valid;
  mrr_pkg::mrr_cmd_t cmd_kind;
  logic [7:0]        cmd_addr;
  logic [7:0]        cmd_op;
  logic              cmd_ready;
  logic              rsp_valid;
  logic [7:0]        rsp_data;
  logic              powered_down;
  logic [2:0]        temp_sensor;
  logic [2:0]        temp_exp;
  logic [7:0]        mr_addr;
  logic [7:0]        mr_data;
  logic              busy;
  logic [7:0]        exp_q[$];
  int                bad_count;
  int                checks_done;
  int                seed;
  int                i;

  mrr_if link ();
  mrr_device #(.SENSOR_INTERVAL_CYC(64)) u_mrr_device (.clock(clock), .reset(reset), .link(link),
    .temp_sensor(temp_sensor), .mr_addr(mr_addr), .mr_data(mr_data), .busy(busy));
  mrr_ctrl u_mrr_ctrl (.clock(clock), .reset(reset), .link(link), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .powered_down(powered_down));
  mrr_monitor u_mrr_monitor (.clock(clock), .reset(reset), .cke(link.cke), .cs_n(link.cs_n),
    .ca_r(link.ca_r), .ca_f(link.ca_f), .dq_o(link.dq_o), .dq_oe(link.dq_oe),
    .dqs_o(link.dqs_o), .dqs_oe(link.dqs_oe));

  always #10 clock = ~clock;

  // user table for ordinary registers
  always @(posedge clock) mr_data <= mr_addr ^ 8'h5a;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  function automatic logic [7:0] expect_of(input logic [7:0] a);
    if (a == 8'h04)
      return {5'h00, temp_exp};
    if (a == 8'h20)
      return 8'h55;
    if (a == 8'h28)
      return 8'hcc;
    if (a >= 8'h40)
      return 8'h00;
    return a ^ 8'h5a;
  endfunction : expect_of

  // holds the request until ready is seen at a falling edge, giving up after 100 cycles
  task automatic send(input mrr_pkg::mrr_cmd_t k, input logic [7:0] a);
    logic rdy;
    int   n;
    n = 0;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_addr  <= a;
    cmd_op    <= 8'($random(seed));
    do
    begin
      @(negedge clock);
      rdy = cmd_ready;
      @(posedge clock);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    cmd_valid <= 1'b0;
    if (k == mrr_pkg::MRR_CMD_MRR)
      exp_q.push_back(expect_of(a));
    check({31'h0, rdy}, 32'h1);
  endtask : send

  always @(negedge clock)
  begin
    if (rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check({24'h0, rsp_data}, {24'h0, exp_q.pop_front()});
    end
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    test_done();
  end

  initial
  begin
    clock       = 1'b0;
    reset       = 1'b1;
    cmd_valid   = 1'b0;
    cmd_kind    = mrr_pkg::MRR_CMD_MRR;
    cmd_addr    = 8'h00;
    cmd_op      = 8'h00;
    temp_sensor = 3'h3;
    temp_exp    = 3'h3;
    seed        = 20417;
    bad_count   = 0;
    checks_done = 0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    send(mrr_pkg::MRR_CMD_MRR, 8'h04);
    // device takes the command one edge after the controller accepts it
    @(posedge clock);
    @(negedge clock);
    check({31'h0, busy}, 32'h1);
    check({24'h0, mr_addr}, 32'h4);
    repeat (20) @(posedge clock);
    temp_exp = 3'($random(seed));
    temp_sensor <= temp_exp;
    // periodic update must land within one interval
    repeat (80) @(posedge clock);
    send(mrr_pkg::MRR_CMD_MRR, 8'h04);
    send(mrr_pkg::MRR_CMD_MRR, 8'h20);
    send(mrr_pkg::MRR_CMD_MRR, 8'h28);
    send(mrr_pkg::MRR_CMD_MRW, 8'h11);
    send(mrr_pkg::MRR_CMD_RD, 8'h00);
    send(mrr_pkg::MRR_CMD_MRR, 8'h41);
    send(mrr_pkg::MRR_CMD_WR, 8'h00);
    send(mrr_pkg::MRR_CMD_MRR, 8'hff);
    for (i = 0; i < 6; i++)
      send(mrr_pkg::MRR_CMD_MRR, 8'($random(seed)));
    send(mrr_pkg::MRR_CMD_PDE, 8'h00);
    repeat (2) @(posedge clock);
    check({31'h0, powered_down}, 32'h1);
    temp_exp = ~temp_exp;
    temp_sensor <= temp_exp;
    repeat (4) @(posedge clock);
    send(mrr_pkg::MRR_CMD_PDX, 8'h00);
    send(mrr_pkg::MRR_CMD_MRR, 8'h04);
    repeat (40) @(posedge clock);
    check(32'(exp_q.size()), 32'h0);
    test_done();
  end
endmodule : tb_mode_register_read_path
